// ==== verilog/scm_defs.vh ====
// Constants for the system clock mode control block: register map, field
// positions, reset values, source codes, mode codes and oscillator counts.
// Assumes it is included once per module by its bare name.
`ifndef SCM_DEFS_VH
`define SCM_DEFS_VH

// Register word indices, decoded from paddr[7:2].
`define SCM_OFF_CTRL      6'h00
`define SCM_OFF_STATUS    6'h01
`define SCM_OFF_CLEAR     6'h02
`define SCM_OFF_ENABLE    6'h03

// Control register fields.
`define SCM_CKS_HI        7
`define SCM_CKS_LO        5
`define SCM_FST_BIT       4
`define SCM_LTO_BIT       3
`define SCM_HTO_BIT       2
`define SCM_IDLE_ENABLE_BIT     1
`define SCM_HL_BIT        0
`define SCM_CTRL_RESET    8'h03
`define SCM_CKS_FIRST_DIV 3'h2

// Event bits in the status, clear and enable registers.
`define SCM_EV_HTO        0
`define SCM_EV_LTO        1
`define SCM_EV_WAKE       2
`define SCM_EV_W          3

// System clock source codes: divided codes equal the divider field.
`define SCM_SRC_OFF       4'h0
`define SCM_SRC_FL        4'h1
`define SCM_SRC_FH        4'h8

// Power modes.
`define SCM_M_RUN         3'h0
`define SCM_M_DEEP        3'h1
`define SCM_M_SUB         3'h2
`define SCM_M_ISTOP       3'h3
`define SCM_M_IRUN        3'h4
`define SCM_M_WAKE        3'h5
`define SCM_M_FAST        3'h6

// High speed oscillator types, a configuration strap.
`define SCM_OSC_XTAL      2'h0
`define SCM_OSC_ERC       2'h1
`define SCM_OSC_INTERNAL_FAST_RC_OSCILLATOR      2'h2

// Stabilisation and wake counts in oscillator cycles.
`define SCM_XTAL_STABLE   11'h400
`define SCM_RC_STABLE     11'h010
`define SCM_SHORT_WAKE    2'h2

`endif

// ==== verilog/scm_osc_sync.v ====
// Synchroniser for one oscillator pin: three flip-flops and a filter.
// Assumes the pin toggles well below half the pclk rate.
`timescale 1ns/10ps
module scm_osc_sync (
  input  wire pclk,
  input  wire presetn,
  input  wire osc_in,
  output reg  level,
  output reg  rise
);
  reg ff1;
  reg ff2;
  reg ff3;

  // The first stage feeds only the second; the filter looks at two and
  // three, so a change counts only once both later stages agree.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff1   <= 1'b0;
      ff2   <= 1'b0;
      ff3   <= 1'b0;
      level <= 1'b0;
      rise  <= 1'b0;
    end else begin
      ff1  <= osc_in;
      ff2  <= ff1;
      ff3  <= ff2;
      rise <= (ff2 == ff3) && ff2 && !level;
      if (ff2 == ff3) begin
        level <= ff2;
      end
    end
  end
endmodule

// ==== verilog/scm_clock_mode.v ====
// System clock mode control: APB register file, power mode sequencer,
// oscillator ready flags, system clock mux (glitch-free except when fH stops under a divided tap) and interrupts.
// Assumes oscillator clocks arrive as pins much slower than pclk and that
// halt and wake requests are one-cycle pulses from logic on pclk.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/10ps
`include "scm_defs.vh"

// Operation
// RL1: Divider field codes 000/001 pick slow clock, 010..111 pick fH/64..fH/2.
// RL2: Select bit high drives undivided fH, low drives divider field choice.
// RL3: Moving the system clock onto the slow source stops the fast oscillator.
// RL4: Slow ready flag low in deep sleep, high 1~2 slow cycles after wake.
// RL5: Fast wake bit runs system on slow clock after wake, crystal only.
// RL6: Fast wake only from sleep keeping slow clock or idle clock stopped.
// RL7: Crystal fast wake runs on slow clock, switches after 1024 cycles.
// RL8: RC sources wake in 15~16 cycles, slow RC in 1~2; fast bit ignored.
// RL9: Watchdog off means no fast wake from deep sleep.
// RL10: Run modes change by register; halt picks sleep or idle by two bits.
// RL11: Slow clock selected and fast oscillator stopped stops fH/16, fH/64.
// RL12: Halt: sleep if idle bit low, else idle stopped or running by keep bit.
// RL13: Software polls the fast ready flag when returning to normal mode.
// RL14: Every clock source switchover is free of runt pulses; a divided tap's high phase is cut short when fH stops.
module scm_clock_mode (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       psel,
  input  wire       penable,
  input  wire       pwrite,
  input  wire [7:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg        pready,
  output reg        pslverr,
  input  wire       high_osc_pin,
  input  wire       low_osc_pin,
  input  wire [1:0] osc_type_strap,
  input  wire       halt_req,
  input  wire       wake_req,
  input  wire       clock_keep_in_idle,
  input  wire       watchdog_or_lvd_on,
  output reg        sys_clk,
  output reg        periph_clk_div16,
  output reg        periph_clk_div64,
  output reg        high_osc_enable,
  output reg        low_osc_enable,
  output reg        cpu_run,
  output reg  [2:0] power_mode,
  output reg        irq
);
  wire       fh_level;
  wire       fh_rise;
  wire       fl_level;
  wire       fl_rise;

  reg  [7:0] ctrl;
  reg  [`SCM_EV_W-1:0] status;
  reg  [`SCM_EV_W-1:0] irq_en;
  reg  [1:0] osc_type;
  reg        strap_taken;
  reg  [2:0] mode;
  reg        fast_wake;
  reg        from_irun;
  reg  [1:0] wake_edges;
  reg  [10:0] hs_cnt;
  reg        high_speed_ready_flag;
  reg  [1:0] ls_cnt;
  reg        low_speed_ready_flag;
  reg  [5:0] div_cnt;
  reg  [3:0] cur_src;
  reg        wake_done;
  reg        hto_d;
  reg        lto_d;

  reg  [3:0] next_src;
  reg        next_high_en;
  reg  [10:0] hs_target;
  reg  [31:0] rd_word;
  reg        rd_ok;
  reg  [`SCM_EV_W-1:0] ev_set;
  reg  [`SCM_EV_W-1:0] ev_clr;
  reg        cur_level;
  reg        new_level;

  wire [2:0] cks  = ctrl[`SCM_CKS_HI:`SCM_CKS_LO];
  wire       hl   = ctrl[`SCM_HL_BIT];
  wire       fst  = ctrl[`SCM_FST_BIT];
  wire       idle = ctrl[`SCM_IDLE_ENABLE_BIT];
  wire       sel_fl = !hl && (cks < `SCM_CKS_FIRST_DIV);
  wire       access = psel && penable && pready;
  wire       wr = access && pwrite;
  wire [5:0] word = paddr[7:2];

  scm_osc_sync u_fh_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .osc_in  (high_osc_pin),
    .level   (fh_level),
    .rise    (fh_rise)
  );

  scm_osc_sync u_fl_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .osc_in  (low_osc_pin),
    .level   (fl_level),
    .rise    (fl_rise)
  );

  // Level of a system clock source; divided taps come from one counter.
  function src_level;
    input [3:0] s;
    input       fh;
    input       fl;
    input [5:0] dc;
    begin
      case (s)
        `SCM_SRC_FL: src_level = fl;        // see RL1
        4'h2:        src_level = dc[5];
        4'h3:        src_level = dc[4];
        4'h4:        src_level = dc[3];
        4'h5:        src_level = dc[2];
        4'h6:        src_level = dc[1];
        4'h7:        src_level = dc[0];
        `SCM_SRC_FH: src_level = fh;        // see RL2
        default:     src_level = 1'b0;
      endcase
    end
  endfunction

  // The strap is a level, so it is caught by the first clock after release.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_type    <= `SCM_OSC_XTAL;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      osc_type    <= osc_type_strap;
      strap_taken <= 1'b1;
    end
  end

  // Source wanted for the current mode and whether fH must run.
  always @* begin
    next_src     = `SCM_SRC_OFF;
    next_high_en = 1'b0;
    case (mode)
      `SCM_M_RUN, `SCM_M_IRUN: begin
        if (hl) begin
          next_src = `SCM_SRC_FH;                     // see RL2
        end else if (sel_fl) begin
          next_src = `SCM_SRC_FL;                     // see RL1
        end else begin
          next_src = {1'b0, cks};                     // see RL1
        end
        next_high_en = !sel_fl;                       // see RL3
      end
      `SCM_M_FAST: begin
        next_src     = `SCM_SRC_FL;                   // see RL7
        next_high_en = 1'b1;
      end
      `SCM_M_WAKE: next_high_en = !sel_fl;
      default:     next_src     = `SCM_SRC_OFF;
    endcase
    hs_target = (osc_type == `SCM_OSC_XTAL) ? `SCM_XTAL_STABLE // see RL7
                : `SCM_RC_STABLE;                     // see RL8
  end

  // Power mode sequencer.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode       <= `SCM_M_RUN;
      fast_wake  <= 1'b0;
      from_irun  <= 1'b0;
      wake_edges <= 2'h0;
      wake_done  <= 1'b0;
    end else begin
      wake_done <= 1'b0;
      case (mode)
        `SCM_M_RUN: begin
          if (halt_req) begin
            if (!idle) begin
              // Deep sleep only when nothing keeps the slow clock alive.
              mode <= watchdog_or_lvd_on ? `SCM_M_SUB // see RL12
                      : `SCM_M_DEEP;
            end else begin
              mode <= clock_keep_in_idle ? `SCM_M_IRUN // see RL10
                      : `SCM_M_ISTOP;                 // see RL12
            end
          end
        end
        `SCM_M_DEEP, `SCM_M_SUB, `SCM_M_ISTOP, `SCM_M_IRUN: begin
          if (wake_req) begin
            // Deep sleep never qualifies: its slow clock is stopped.
            fast_wake  <= (osc_type == `SCM_OSC_XTAL) && fst &&
                          !sel_fl &&
                          (mode == `SCM_M_SUB ||
                           mode == `SCM_M_ISTOP);     // see RL5 see RL6 see RL9
            from_irun  <= (mode == `SCM_M_IRUN);
            wake_edges <= 2'h0;
            mode       <= `SCM_M_WAKE;
          end
        end
        `SCM_M_WAKE: begin
          if (fast_wake) begin
            if (fl_rise) begin
              wake_edges <= wake_edges + 2'h1;
              if (wake_edges + 2'h1 == `SCM_SHORT_WAKE) begin
                mode <= `SCM_M_FAST;                  // see RL7
              end
            end
          end else if (from_irun || sel_fl) begin
            if (sel_fl ? fl_rise : fh_rise) begin
              wake_edges <= wake_edges + 2'h1;
              if (wake_edges + 2'h1 == `SCM_SHORT_WAKE) begin
                mode      <= `SCM_M_RUN;              // see RL8
                wake_done <= 1'b1;
              end
            end
          end else if (high_speed_ready_flag) begin
            mode      <= `SCM_M_RUN;                  // see RL8
            wake_done <= 1'b1;
          end
        end
        `SCM_M_FAST: begin
          if (high_speed_ready_flag) begin
            mode      <= `SCM_M_RUN;                  // see RL7
            wake_done <= 1'b1;
          end
        end
        default: mode <= `SCM_M_RUN;
      endcase
    end
  end

  // Ready flags: counted from oscillator edges, dropped with the oscillator.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_cnt <= 11'h000;
      high_speed_ready_flag    <= 1'b0;
      ls_cnt <= 2'h0;
      low_speed_ready_flag    <= 1'b0;
      hto_d  <= 1'b0;
      lto_d  <= 1'b0;
    end else begin
      hto_d <= high_speed_ready_flag;
      lto_d <= low_speed_ready_flag;
      if (!high_osc_enable) begin
        hs_cnt <= 11'h000;
        high_speed_ready_flag    <= 1'b0;
      end else if (fh_rise && !high_speed_ready_flag) begin
        hs_cnt <= hs_cnt + 11'h001;
        if (hs_cnt + 11'h001 == hs_target) begin
          high_speed_ready_flag <= 1'b1;                                // see RL7 see RL8
        end
      end
      if (!low_osc_enable) begin
        ls_cnt <= 2'h0;
        low_speed_ready_flag    <= 1'b0;                               // see RL4
      end else if (fl_rise && !low_speed_ready_flag) begin
        ls_cnt <= ls_cnt + 2'h1;
        if (ls_cnt + 2'h1 == `SCM_SHORT_WAKE) begin
          low_speed_ready_flag <= 1'b1;                                // see RL4
        end
      end
    end
  end

  // Glitch-free mux: a pending change first lets the present source finish
  // its high phase, holds the output low, and takes the new source only at
  // one of its low phases; no high phase is cut short but a divided tap's, when fH stops and clears div_cnt.
  always @* begin
    cur_level = src_level(cur_src, fh_level, fl_level, div_cnt);
    new_level = src_level(next_src, fh_level, fl_level, div_cnt);
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_src          <= `SCM_SRC_FH;
      sys_clk          <= 1'b0;
      div_cnt          <= 6'h00;
      periph_clk_div16 <= 1'b0;
      periph_clk_div64 <= 1'b0;
      high_osc_enable  <= 1'b1;
      low_osc_enable   <= 1'b1;
      cpu_run          <= 1'b1;
      power_mode       <= `SCM_M_RUN;
    end else begin
      high_osc_enable <= next_high_en;                // see RL3
      low_osc_enable  <= (mode != `SCM_M_DEEP);       // see RL4 see RL9
      cpu_run         <= (mode == `SCM_M_RUN) || (mode == `SCM_M_FAST);
      power_mode      <= mode;
      if (!high_osc_enable) begin
        div_cnt <= 6'h00;
      end else if (fh_rise) begin
        div_cnt <= div_cnt + 6'h01;
      end
      // A stopped fH stops the peripheral taps with it.
      periph_clk_div16 <= high_osc_enable && div_cnt[3];   // see RL11
      periph_clk_div64 <= high_osc_enable && div_cnt[5];   // see RL11
      if (cur_src == next_src) begin
        sys_clk <= cur_level;
      end else if (sys_clk && cur_level) begin
        sys_clk <= 1'b1;                              // see RL14
      end else begin
        sys_clk <= 1'b0;
        if (!new_level) begin
          cur_src <= next_src;                        // see RL14
        end
      end
    end
  end

  // Register read mux and event collection.
  always @* begin
    rd_word = 32'h00000000;
    rd_ok   = 1'b1;
    case (word)
      `SCM_OFF_CTRL:   rd_word[7:0] = {cks, fst, low_speed_ready_flag, high_speed_ready_flag, idle, hl};
      `SCM_OFF_STATUS: rd_word[`SCM_EV_W-1:0] = status;
      `SCM_OFF_CLEAR:  rd_word = 32'h00000000;
      `SCM_OFF_ENABLE: rd_word[`SCM_EV_W-1:0] = irq_en;
      default:         rd_ok = 1'b0;
    endcase
    ev_set = {wake_done, low_speed_ready_flag && !lto_d, high_speed_ready_flag && !hto_d};
    ev_clr = (wr && word == `SCM_OFF_CLEAR) ? pwdata[`SCM_EV_W-1:0]
                                            : {`SCM_EV_W{1'b0}};
  end

  // APB slave: one wait state, then the access completes.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      ctrl    <= `SCM_CTRL_RESET;
      status  <= {`SCM_EV_W{1'b0}};
      irq_en  <= {`SCM_EV_W{1'b0}};
      irq     <= 1'b0;
    end else begin
      if (psel && penable && !pready) begin
        pready  <= 1'b1;
        pslverr <= !rd_ok;
        prdata  <= pwrite ? 32'h00000000 : rd_word;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
      if (wr && word == `SCM_OFF_CTRL) begin
        // Ready flags are read-only and never stored.
        ctrl[`SCM_CKS_HI:`SCM_CKS_LO] <= pwdata[`SCM_CKS_HI:`SCM_CKS_LO];
        ctrl[`SCM_FST_BIT]   <= pwdata[`SCM_FST_BIT];    // see RL5
        ctrl[`SCM_IDLE_ENABLE_BIT] <= pwdata[`SCM_IDLE_ENABLE_BIT];  // see RL10
        ctrl[`SCM_HL_BIT]    <= pwdata[`SCM_HL_BIT];     // see RL10
      end
      if (wr && word == `SCM_OFF_ENABLE) begin
        irq_en <= pwdata[`SCM_EV_W-1:0];
      end
      // A new event wins over a clear in the same cycle.
      status <= (status & ~ev_clr) | ev_set;
      irq    <= |(status & irq_en);
    end
  end
endmodule

// ==== tb/scm_clock_mode_props.sv ====
// Checker for the clock mode block: bus handshake, power modes, clocks.
// Assumes it is bound to scm_clock_mode and sees only its ports.
`timescale 1ns/10ps
module scm_clock_mode_props (
  input wire       pclk,
  input wire       presetn,
  input wire       psel,
  input wire       penable,
  input wire       pready,
  input wire       pslverr,
  input wire       halt_req,
  input wire       wake_req,
  input wire [2:0] power_mode,
  input wire       cpu_run,
  input wire       high_osc_enable,
  input wire       low_osc_enable,
  input wire       periph_clk_div16,
  input wire       periph_clk_div64,
  input wire       sys_clk
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready_answer;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_answer: assert property (p_ready_answer)
    else $error("access not answered in one wait state");
  property p_ready_cause;
    pready |-> $past(psel && penable) ##1 !pready;
  endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("ready without access or longer than one cycle");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error flag without ready");
  property p_halt_mode;
    halt_req && power_mode == 3'h0 |->
      ##[1:3] (power_mode inside {[3'h1:3'h4]});
  endproperty
  a_halt_mode: assert property (p_halt_mode)
    else $error("halt did not reach a sleep or idle mode");
  property p_wake_mode;
    wake_req && (power_mode inside {[3'h1:3'h4]}) |->
      ##[1:3] (power_mode inside {3'h0, 3'h5, 3'h6});
  endproperty
  a_wake_mode: assert property (p_wake_mode)
    else $error("wake did not leave the sleep or idle mode");
  property p_sleep_cpu;
    (!wake_req && (power_mode inside {[3'h1:3'h4]}))[*3] |-> !cpu_run;
  endproperty
  a_sleep_cpu: assert property (p_sleep_cpu)
    else $error("cpu runs in a sleep or idle mode");
  property p_sleep_fast_off;
    (!wake_req && (power_mode inside {[3'h1:3'h3]}))[*3]
      |-> !high_osc_enable;
  endproperty
  a_sleep_fast_off: assert property (p_sleep_fast_off)
    else $error("fast oscillator on with system clock stopped");
  property p_deep_slow_off;
    (!wake_req && power_mode == 3'h1)[*3] |-> !low_osc_enable;
  endproperty
  a_deep_slow_off: assert property (p_deep_slow_off)
    else $error("slow oscillator on in deep sleep");
  property p_taps_off;
    (!high_osc_enable)[*6] |-> !periph_clk_div16 && !periph_clk_div64;
  endproperty
  a_taps_off: assert property (p_taps_off)
    else $error("divided taps run with fast oscillator off");
  property p_no_runt;
    $rose(sys_clk) |=> sys_clk[*3];
  endproperty
  a_no_runt: assert property (p_no_runt)
    else $error("short high pulse on system clock");

  c_halt: cover property (halt_req && power_mode == 3'h0);
  c_err: cover property (pslverr);
  c_deep: cover property (power_mode == 3'h1 && !low_osc_enable);
  c_fast: cover property (power_mode == 3'h6 && cpu_run);
endmodule

bind scm_clock_mode scm_clock_mode_props scm_clock_mode_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .halt_req(halt_req),
  .wake_req(wake_req), .power_mode(power_mode), .cpu_run(cpu_run),
  .high_osc_enable(high_osc_enable), .low_osc_enable(low_osc_enable),
  .periph_clk_div16(periph_clk_div16),
  .periph_clk_div64(periph_clk_div64), .sys_clk(sys_clk));

// ==== tb/test_scm_clock_mode.sv ====
// Self-checking bench for the clock mode block: registers, clock
// selection, power modes, wake timing and the interrupt.
// Assumes the checker is bound to the design from its own file.
`timescale 1ns/10ps
`define chk(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_scm_clock_mode;
  logic        pclk, presetn, psel, penable, pwrite, halt_req, wake_req;
  logic        keep, wd_on, fh_pin, fl_pin, pready, pslverr, sys_clk;
  logic        div16, div64, fh_en, fl_en, cpu_run, irq, e, s0, fast;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, d;
  logic [2:0]  power_mode;
  logic [1:0]  strap;
  int          n_errors, n_compared, seed, n, i, x, y, fh_t, fl_t;

  // External RC strap keeps most wake counts short; the last scenario
  // resets into crystal mode to reach the fast wake path.
  scm_clock_mode scm_clock_mode_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .high_osc_pin(fh_pin),
    .low_osc_pin(fl_pin), .osc_type_strap(strap), .halt_req(halt_req),
    .wake_req(wake_req), .clock_keep_in_idle(keep),
    .watchdog_or_lvd_on(wd_on), .sys_clk(sys_clk),
    .periph_clk_div16(div16), .periph_clk_div64(div64),
    .high_osc_enable(fh_en), .low_osc_enable(fl_en), .cpu_run(cpu_run),
    .power_mode(power_mode), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Oscillator pins stand still while their enable is low.
  always @(posedge pclk) begin
    fh_t <= (fh_t == 7) ? 0 : fh_t + 1;
    fl_t <= (fl_t == 11) ? 0 : fl_t + 1;
    if (fh_t == 7 && fh_en === 1'b1)
      fh_pin <= !fh_pin;
    if (fl_t == 11 && fl_en === 1'b1)
      fl_pin <= !fl_pin;
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic count_rises;
    n = 0;
    s0 = sys_clk;
    repeat (2048) begin
      @(posedge pclk);
      if (sys_clk === 1'b1 && s0 === 1'b0)
        n++;
      s0 = sys_clk;
    end
  endtask

  function automatic int exp_rises(input logic [2:0] c, input logic hl);
    if (hl)
      return 2048 / 16;
    if (c < 3'h2)
      return 2048 / 24;
    return 2048 / (16 << (8 - c));
  endfunction

  task automatic final_report;
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    final_report;
  end

  initial begin
    seed = 32'hfa23a70f;
    {psel, penable, pwrite, halt_req, wake_req, keep, wd_on} = 7'h00;
    strap = 2'h1;
    {fh_pin, fl_pin, paddr, pwdata} = 42'h0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    `chk(r & 32'hFFFFFFF3, 32'h00000003)
    for (i = 0; i < 6; i++) begin
      d = $random(seed);
      apb(1'b1, 8'h00, d);
      apb(1'b0, 8'h00, 32'h0);
      `chk(r & 32'hFFFFFFF3, d & 32'h000000F3)
    end
    for (i = 0; i < 9; i++) begin
      d = {24'h0, i[2:0], 4'h0, i == 8};
      apb(1'b1, 8'h00, d);
      repeat (512) @(posedge pclk);
      `chk(fh_en, d[0] || d[7:6] != 2'h0)
      if (d[7:6] == 2'h0 && !d[0]) `chk({div16, div64}, 2'h0)
      x = exp_rises(d[7:5], d[0]);
      count_rises;
      `chk(n >= x - 1 && n <= x + 1, 1'b1)
    end
    apb(1'b1, 8'h00, 32'h00000001);
    repeat (400) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    `chk(r[3:2], 2'h3)
    apb(1'b0, 8'h04, 32'h0);
    `chk(r[1:0], 2'h3)
    apb(1'b1, 8'h0C, 32'h00000001);
    repeat (3) @(posedge pclk);
    `chk(irq, 1'b1)
    apb(1'b1, 8'h0C, 32'h0);
    repeat (3) @(posedge pclk);
    `chk(irq, 1'b0)
    apb(1'b1, 8'h0C, 32'h00000001);
    apb(1'b1, 8'h08, 32'h00000007);
    repeat (3) @(posedge pclk);
    `chk(irq, 1'b0)
    apb(1'b0, 8'h08, 32'h0);
    `chk(r, 32'h0)
    apb(1'b0, 8'h10, 32'h0);
    `chk({e, r}, {1'b1, 32'h0})
    apb(1'b1, 8'h0C, 32'h0);
    for (i = 0; i < 5; i++) begin
      if (i == 4) begin
        // Crystal strap, fast wake from sleep that keeps the slow clock.
        strap <= 2'h0;
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (80) @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0);
        `chk(r & 32'hFFFFFFF3, 32'h00000003)
      end
      keep <= i[0];
      wd_on <= i[0] || i[2];
      if (i[2])
        apb(1'b1, 8'h00, 32'h000000F0);
      else
        apb(1'b1, 8'h00, {24'h0, 3'h0, 1'b1, 2'h0, i[1], 1'b1});
      x = i[2] ? 2 : i[1] ? 3 + i[0] : 1 + i[0];
      repeat ($unsigned($random(seed)) % 8 + 1) @(posedge pclk);
      halt_req <= 1'b1;
      @(posedge pclk);
      halt_req <= 1'b0;
      repeat (8) @(posedge pclk);
      `chk(power_mode, x[2:0])
      `chk(cpu_run, 1'b0)
      `chk(fl_en, x != 1)
      apb(1'b0, 8'h00, 32'h0);
      `chk(r[3], x != 1)
      wake_req <= 1'b1;
      @(posedge pclk);
      wake_req <= 1'b0;
      n = 0;
      fast = 1'b0;
      while (power_mode !== 3'h0) begin
        @(posedge pclk);
        n++;
        if (power_mode === 3'h6)
          fast = 1'b1;
      end
      y = (x == 4) ? 2 : i[2] ? 1024 : 16;
      `chk(n >= (y - 1) * 16 && n <= y * 16 + 12, 1'b1)
      `chk(fast, i[2])
      repeat (80) @(posedge pclk);
      apb(1'b0, 8'h00, 32'h0);
      `chk(r[3], 1'b1)
      apb(1'b0, 8'h04, 32'h0);
      `chk(r[2], 1'b1)
      apb(1'b1, 8'h08, 32'h00000004);
    end
    final_report;
  end
endmodule
